//--- rtl/dfd_pkg.sv
package dfd_pkg;

  // instruction word layout
  localparam int WORD_W     = 24;
  localparam int OPC_W      = 8;
  localparam int OPND_W     = 16;
  localparam int OPC_MSB    = 23;
  localparam int OPC_LSB    = 16;
  localparam int OPND_MSB   = 15;

  // opcode class select bits
  localparam int CLS_MSB    = 7;
  localparam int CLS_LSB    = 5;
  localparam logic [2:0] CLS_CTRL_LO = 3'h0;
  localparam logic [2:0] CLS_LIT_MOV = 3'h1;
  localparam logic [2:0] CLS_LIT_ALU = 3'h2;
  localparam logic [2:0] CLS_WORKING_ZERO_ALIAS    = 3'h3;
  localparam logic [2:0] CLS_FREG    = 3'h4;
  localparam logic [2:0] CLS_BIT     = 3'h5;
  localparam logic [2:0] CLS_DSP     = 3'h6;
  localparam logic [2:0] CLS_CTRL_HI = 3'h7;

  // special opcodes
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_TWO_A    = 8'h02;
  localparam logic [7:0] OPC_TWO_B    = 8'h04;
  localparam logic [7:0] OPC_TWO_C    = 8'h07;
  localparam logic [7:0] OPC_DW_MOVE  = 8'h7E;

  // address modifier codes
  localparam logic [1:0] MOD_DIRECT   = 2'h0;

  // field positions inside the opcode and operand
  localparam int BYTE_BIT    = 0;
  localparam int FILE_BIT    = 1;
  localparam int BASE_LSB    = 12;
  localparam int DEST_LSB    = 8;
  localparam int DMOD_LSB    = 6;
  localparam int SRC_LSB     = 2;
  localparam int SMOD_LSB    = 0;
  localparam int FADDR_W     = 13;
  localparam int FDEST_BIT   = 13;
  localparam int BIT_IND_BIT = 11;
  localparam int BIT_FILE    = 10;
  localparam int BFADDR_W    = 10;
  localparam int ACC_BIT     = 15;
  localparam int PAIR_LSB    = 12;
  localparam int XOP_LSB     = 10;
  localparam int XDST_LSB    = 8;
  localparam int YOP_LSB     = 6;
  localparam int YDST_LSB    = 4;
  localparam int AWB_LSB     = 2;

  typedef enum logic [4:0] {
    GRP_WORD = 5'b00001,
    GRP_BIT  = 5'b00010,
    GRP_LIT  = 5'b00100,
    GRP_DSP  = 5'b01000,
    GRP_CTRL = 5'b10000
  } dfd_group_e;

  typedef enum logic [4:0] {
    ST_FIRST  = 5'b00001,
    ST_SECOND = 5'b00010,
    ST_SKIP   = 5'b00100,
    ST_SKIP2  = 5'b01000,
    ST_HOLD   = 5'b10000
  } dfd_state_e;

  typedef struct packed {
    dfd_group_e         group;
    logic [7:0]         opcode;
    logic [15:0]        operand;
    logic               is_two_word;
    logic               is_nop;
    logic               is_dword_move;
    logic               file_form;
    logic               lit_alu;
    logic               byte_op;
    logic [3:0]         base_source_reg;
    logic [3:0]         second_source_reg;
    logic [1:0]         src_mode;
    logic [3:0]         result_dest_reg;
    logic [1:0]         dest_mode;
    logic               dest_explicit;
    logic [12:0]        file_addr;
    logic               dest_to_file;
    logic               target_is_file;
    logic [3:0]         bit_pos;
    logic               bit_indirect;
    logic [15:0]        literal;
    logic               acc_b;
    logic [2:0]         mac_pair;
    logic [1:0]         x_op;
    logic [1:0]         x_dest;
    logic [1:0]         y_op;
    logic [1:0]         y_dest;
    logic [1:0]         awb;
    logic [15:0]        ext_word;
  } dfd_dec_s;

endpackage : dfd_pkg

//--- rtl/dfd_field_extract.sv
`timescale 1ns/1ps
module dfd_field_extract (
  input  wire logic [23:0]     first_word,
  input  wire logic [23:0]     second_word,
  output dfd_pkg::dfd_dec_s    dec
);

  logic [7:0]  opc;
  logic [15:0] opn;
  logic [2:0]  cls;

  assign opc = first_word[dfd_pkg::OPC_MSB:dfd_pkg::OPC_LSB];
  assign opn = first_word[dfd_pkg::OPND_MSB:0];
  assign cls = opc[dfd_pkg::CLS_MSB:dfd_pkg::CLS_LSB];

  always_comb begin
    dec = '0;
    dec.opcode        = opc;
    dec.operand       = opn;
    dec.is_two_word   = (opc == dfd_pkg::OPC_TWO_A) || (opc == dfd_pkg::OPC_TWO_B) ||
                        (opc == dfd_pkg::OPC_TWO_C);
    dec.ext_word      = dec.is_two_word ? second_word[dfd_pkg::OPND_MSB:0] : 16'h0000;
    dec.is_nop        = (opc == dfd_pkg::OPC_NOP);
    dec.is_dword_move = (opc == dfd_pkg::OPC_DW_MOVE);
    dec.byte_op       = opc[dfd_pkg::BYTE_BIT];
    case (cls)
      dfd_pkg::CLS_WORKING_ZERO_ALIAS, dfd_pkg::CLS_FREG: dec.group = dfd_pkg::GRP_WORD;
      dfd_pkg::CLS_BIT: dec.group = dfd_pkg::GRP_BIT;
      dfd_pkg::CLS_LIT_MOV, dfd_pkg::CLS_LIT_ALU: dec.group = dfd_pkg::GRP_LIT;
      dfd_pkg::CLS_DSP: dec.group = dfd_pkg::GRP_DSP;
      default: dec.group = dfd_pkg::GRP_CTRL;
    endcase
    case (cls)
      dfd_pkg::CLS_WORKING_ZERO_ALIAS: begin
        dec.base_source_reg   = opn[dfd_pkg::BASE_LSB +: 4];
        dec.second_source_reg = opn[dfd_pkg::SRC_LSB +: 4];
        dec.src_mode          = opn[dfd_pkg::SMOD_LSB +: 2];
        dec.result_dest_reg   = opn[dfd_pkg::DEST_LSB +: 4];
        dec.dest_mode         = opn[dfd_pkg::DMOD_LSB +: 2];
        dec.dest_explicit     = 1'b1;
      end
      dfd_pkg::CLS_FREG: begin
        dec.file_form    = 1'b1;
        dec.file_addr    = opn[dfd_pkg::FADDR_W-1:0];
        dec.dest_to_file = opn[dfd_pkg::FDEST_BIT];
      end
      dfd_pkg::CLS_BIT: begin
        dec.bit_indirect      = opn[dfd_pkg::BIT_IND_BIT];
        dec.target_is_file    = opn[dfd_pkg::BIT_FILE];
        dec.bit_pos           = opn[dfd_pkg::BASE_LSB +: 4];
        dec.base_source_reg   = opn[dfd_pkg::BASE_LSB +: 4];
        dec.file_addr         = {3'b000, opn[dfd_pkg::BFADDR_W-1:0]};
        dec.second_source_reg = opn[dfd_pkg::SRC_LSB +: 4];
        dec.src_mode          = opn[dfd_pkg::SMOD_LSB +: 2];
      end
      dfd_pkg::CLS_LIT_MOV: begin
        dec.target_is_file = opc[dfd_pkg::FILE_BIT];
        if (opc[dfd_pkg::FILE_BIT]) begin
          dec.literal   = {8'h00, opn[15:8]};
          dec.file_addr = {5'b00000, opn[7:0]};
        end else begin
          dec.literal         = {4'h0, opn[15:4]};
          dec.result_dest_reg = opn[3:0];
        end
      end
      dfd_pkg::CLS_LIT_ALU: begin
        dec.lit_alu         = 1'b1;
        dec.base_source_reg = opn[dfd_pkg::BASE_LSB +: 4];
        dec.literal         = {10'h000, opn[11:6]};
        dec.dest_explicit   = (opn[5:2] != opn[dfd_pkg::BASE_LSB +: 4]) ||
                              (opn[1:0] != dfd_pkg::MOD_DIRECT);
        dec.result_dest_reg = dec.dest_explicit ? opn[5:2] : opn[dfd_pkg::BASE_LSB +: 4];
        dec.dest_mode       = dec.dest_explicit ? opn[1:0] : dfd_pkg::MOD_DIRECT;
      end
      dfd_pkg::CLS_DSP: begin
        dec.acc_b    = opn[dfd_pkg::ACC_BIT];
        dec.mac_pair = opn[dfd_pkg::PAIR_LSB +: 3];
        dec.x_op     = opn[dfd_pkg::XOP_LSB +: 2];
        dec.x_dest   = opn[dfd_pkg::XDST_LSB +: 2];
        dec.y_op     = opn[dfd_pkg::YOP_LSB +: 2];
        dec.y_dest   = opn[dfd_pkg::YDST_LSB +: 2];
        dec.awb      = opn[dfd_pkg::AWB_LSB +: 2];
      end
      default: dec.literal = opn;
    endcase
  end

endmodule : dfd_field_extract

//--- rtl/dfd_decoder.sv
// Overview of operation
// - each single-word instruction is 24 bits: an 8-bit opcode and the rest operand fields.
// - three opcodes span two words, and the second word is fetched before issue.
// - every opcode falls in one of five groups: word/byte, bit, literal, dsp, control.
// - working-register word ops yield base source, moded second source and moded destination.
// - file-register word ops yield a file address and a select of file or working_zero_alias.
// - bit ops take a register or file target and a bit from a literal or a base register.
// - literal moves yield a literal and a register or file target.
// - literal arithmetic uses a base source and a literal, with a destination only if different.
// - mac ops yield accumulator select, register pair, x/y prefetch ops and targets, write-back.
// - a word whose upper eight bits are zero, run alone, acts as a nop.
// - a true condition or a program counter change adds one nop cycle.
// - a taken skip costs two or three cycles by skipped length; double-word moves take two.
`timescale 1ns/1ps
module dfd_decoder (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                fetch_valid,
  input  wire logic [23:0]         fetch_word,
  output logic                     fetch_ready,
  input  wire logic                exec_pc_change,
  input  wire logic                exec_skip,
  output logic                     issue_valid,
  output logic                     issue_nop,
  output dfd_pkg::dfd_dec_s        issue
);

  dfd_pkg::dfd_state_e state_reg;
  dfd_pkg::dfd_state_e state_next;
  logic [23:0]         first_reg;
  logic [23:0]         ext_src;
  logic [23:0]         dec_first;
  dfd_pkg::dfd_dec_s   dec;
  logic                take;
  logic                word_two;
  logic                pc_now;
  logic                skip_now;

  ////////////////////////////////////////////////////////////////////////////
  // control terms

  assign word_two = (fetch_word[dfd_pkg::OPC_MSB:dfd_pkg::OPC_LSB] == dfd_pkg::OPC_TWO_A) ||
                    (fetch_word[dfd_pkg::OPC_MSB:dfd_pkg::OPC_LSB] == dfd_pkg::OPC_TWO_B) ||
                    (fetch_word[dfd_pkg::OPC_MSB:dfd_pkg::OPC_LSB] == dfd_pkg::OPC_TWO_C);

  assign pc_now   = (state_reg == dfd_pkg::ST_FIRST) && issue_valid && exec_pc_change;
  assign skip_now = (state_reg == dfd_pkg::ST_SKIP) ||
                    ((state_reg == dfd_pkg::ST_FIRST) && issue_valid && exec_skip && !exec_pc_change);

  assign fetch_ready = !pc_now && (state_reg != dfd_pkg::ST_HOLD);
  assign take        = fetch_valid && fetch_ready;

  assign dec_first = (state_reg == dfd_pkg::ST_SECOND) ? first_reg : fetch_word;
  assign ext_src   = (state_reg == dfd_pkg::ST_SECOND) ? fetch_word : 24'h00_0000;

  dfd_field_extract u_extract (
    .first_word  (dec_first),
    .second_word (ext_src),
    .dec         (dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dfd_pkg::ST_FIRST: begin
        if (pc_now) begin
          state_next = dfd_pkg::ST_FIRST;
        end else if (skip_now) begin
          if (!fetch_valid) begin
            state_next = dfd_pkg::ST_SKIP;
          end else if (word_two) begin
            state_next = dfd_pkg::ST_SKIP2;
          end
        end else if (take && word_two) begin
          state_next = dfd_pkg::ST_SECOND;
        end else if (take && dec.is_dword_move) begin
          state_next = dfd_pkg::ST_HOLD;
        end
      end
      dfd_pkg::ST_SECOND: begin
        if (fetch_valid) begin
          state_next = dfd_pkg::ST_FIRST;
        end
      end
      dfd_pkg::ST_SKIP: begin
        if (fetch_valid) begin
          state_next = word_two ? dfd_pkg::ST_SKIP2 : dfd_pkg::ST_FIRST;
        end
      end
      dfd_pkg::ST_SKIP2: begin
        if (fetch_valid) begin
          state_next = dfd_pkg::ST_FIRST;
        end
      end
      dfd_pkg::ST_HOLD: state_next = dfd_pkg::ST_FIRST;
      default: state_next = dfd_pkg::ST_FIRST;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= dfd_pkg::ST_FIRST;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      first_reg <= 24'h00_0000;
    end else if (take && (state_reg == dfd_pkg::ST_FIRST) && word_two && !skip_now) begin
      first_reg <= fetch_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue outputs

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      issue_valid <= 1'b0;
      issue_nop   <= 1'b0;
    end else begin
      issue_valid <= 1'b0;
      issue_nop   <= 1'b0;
      case (state_reg)
        dfd_pkg::ST_FIRST: begin
          if (pc_now) begin
            issue_nop <= 1'b1;
          end else if (skip_now) begin
            issue_nop <= fetch_valid;
          end else if (take && !word_two) begin
            issue_valid <= 1'b1;
          end
        end
        dfd_pkg::ST_SECOND: issue_valid <= fetch_valid;
        dfd_pkg::ST_SKIP, dfd_pkg::ST_SKIP2: issue_nop <= fetch_valid;
        dfd_pkg::ST_HOLD: issue_nop <= 1'b1;
        default: issue_nop <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      issue <= '0;
    end else if ((state_reg == dfd_pkg::ST_SECOND) && fetch_valid) begin
      issue <= dec;
    end else if ((state_reg == dfd_pkg::ST_FIRST) && take && !skip_now && !word_two) begin
      issue <= dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_opcode_split;
    (state_reg == dfd_pkg::ST_FIRST) && take && !skip_now && !word_two
      |=> issue_valid && (issue.opcode == $past(fetch_word[23:16])) &&
          (issue.operand == $past(fetch_word[15:0]));
  endproperty
  a_opcode_split: assert property (p_opcode_split) else $error("opcode split wrong");

  property p_two_word;
    (state_reg == dfd_pkg::ST_FIRST) && take && word_two && !skip_now
      |=> !issue_valid && (state_reg == dfd_pkg::ST_SECOND) ##1
          (!$past(fetch_valid) || issue_valid && issue.is_two_word);
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word issue wrong");

  property p_group_onehot;
    issue_valid |-> $onehot(issue.group);
  endproperty
  a_group_onehot: assert property (p_group_onehot) else $error("group not one-hot");

  property p_lit_dest;
    issue_valid && issue.lit_alu && !issue.dest_explicit |-> issue.result_dest_reg == issue.base_source_reg;
  endproperty
  a_lit_dest: assert property (p_lit_dest) else $error("literal destination wrong");

  property p_zero_nop;
    (state_reg == dfd_pkg::ST_FIRST) && take && !skip_now && (fetch_word[23:16] == 8'h00)
      |=> issue_valid && issue.is_nop;
  endproperty
  a_zero_nop: assert property (p_zero_nop) else $error("zero opcode not nop");

  property p_pc_change;
    pc_now |-> !fetch_ready ##1 (issue_nop && !issue_valid);
  endproperty
  a_pc_change: assert property (p_pc_change) else $error("redirect nop missing");

  property p_skip_single;
    skip_now && fetch_valid && !word_two |=> issue_nop && (state_reg == dfd_pkg::ST_FIRST);
  endproperty
  a_skip_single: assert property (p_skip_single) else $error("single skip wrong");

  property p_skip_double;
    skip_now && fetch_valid && word_two |=> issue_nop && (state_reg == dfd_pkg::ST_SKIP2);
  endproperty
  a_skip_double: assert property (p_skip_double) else $error("double skip wrong");

  property p_dword_move;
    (state_reg == dfd_pkg::ST_FIRST) && take && !skip_now && dec.is_dword_move
      |=> issue_valid && !fetch_ready ##1 (issue_nop && !issue_valid && fetch_ready);
  endproperty
  a_dword_move: assert property (p_dword_move) else $error("double move not two cycles");

endmodule : dfd_decoder

//--- verif/dfd_prog_model.sv
`timescale 1ns/1ps
module dfd_prog_model (
  input  wire logic        core_clk,
  input  wire logic        fetch_ready,
  input  wire logic        issue_valid,
  output logic             fetch_valid,
  output logic [23:0]      fetch_word,
  output logic             exec_pc_change,
  output logic             exec_skip
);
  logic [23:0] words[$];
  logic [1:0]  codes[$];
  logic        slow;
  logic        took;
  logic        fv;
  logic [1:0]  c;
  int          gap;

  initial begin
    slow = 1'b0;
    took = 1'b0;
    gap = 0;
    fetch_valid = 1'b0;
    fetch_word = 24'h00_0000;
    exec_pc_change = 1'b0;
    exec_skip = 1'b0;
  end

  // note a word taken
  always @(posedge core_clk) begin
    if (fetch_valid && fetch_ready) begin
      took = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // datapath answer and word offer, held until taken
  always @(negedge core_clk) begin
    c = 2'h0;
    if (issue_valid === 1'b1 && codes.size() > 0) begin
      c = codes.pop_front();
    end
    exec_pc_change <= c[0];
    exec_skip      <= c[1];
    fv = fetch_valid;
    if (took) begin
      void'(words.pop_front());
      took = 1'b0;
      fv = 1'b0;
      gap = slow ? $urandom_range(2, 0) : 0;
    end
    if (!fv && gap > 0) begin
      gap--;
    end else if (!fv && words.size() > 0) begin
      fv = 1'b1;
    end
    fetch_valid <= fv;
    fetch_word  <= fv ? words[0] : ~fetch_word;
  end
endmodule : dfd_prog_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic               core_clk;
  logic               sys_rst;
  logic               fetch_valid;
  logic [23:0]        fetch_word;
  logic               fetch_ready;
  logic               exec_pc_change;
  logic               exec_skip;
  logic               issue_valid;
  logic               issue_nop;
  dfd_pkg::dfd_dec_s  issue;
  logic [48:0]        exp_q[$];
  logic [48:0]        e;
  logic [48:0]        got;
  int                 err_total;
  int                 checked;

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  dfd_decoder dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .exec_pc_change(exec_pc_change),
    .exec_skip(exec_skip), .issue_valid(issue_valid), .issue_nop(issue_nop), .issue(issue));

  dfd_prog_model prog_u (.core_clk(core_clk), .fetch_ready(fetch_ready), .issue_valid(issue_valid),
    .fetch_valid(fetch_valid), .fetch_word(fetch_word), .exec_pc_change(exec_pc_change),
    .exec_skip(exec_skip));

  function automatic dfd_pkg::dfd_dec_s mk(logic [23:0] w, logic [15:0] x, logic two);
    dfd_pkg::dfd_dec_s d;
    logic [15:0]       o;
    d = '0;
    o = w[15:0];
    d.opcode = w[23:16];
    d.operand = o;
    d.is_two_word = two;
    d.ext_word = x;
    d.is_nop = (w[23:16] == dfd_pkg::OPC_NOP);
    d.base_source_reg = o[15:12];
    d.result_dest_reg = o[11:8];
    d.dest_mode = o[7:6];
    d.second_source_reg = o[5:2];
    d.src_mode = o[1:0];
    d.byte_op = w[16];
    d.file_addr = o[12:0];
    d.dest_to_file = o[13];
    d.bit_pos = o[15:12];
    d.bit_indirect = o[11];
    d.target_is_file = o[10];
    d.acc_b = o[15];
    d.mac_pair = o[14:12];
    d.x_op = o[11:10];
    d.x_dest = o[9:8];
    d.y_op = o[7:6];
    d.y_dest = o[5:4];
    d.awb = o[3:2];
    d.group = dfd_pkg::GRP_CTRL;
    case (w[23:21])
      dfd_pkg::CLS_LIT_MOV: begin
        d.group = dfd_pkg::GRP_LIT;
        d.target_is_file = w[17];
        d.literal = w[17] ? {8'h00, o[15:8]} : {4'h0, o[15:4]};
        d.result_dest_reg = o[3:0];
      end
      dfd_pkg::CLS_LIT_ALU: begin
        d.group = dfd_pkg::GRP_LIT;
        d.literal = {10'h000, o[11:6]};
        d.result_dest_reg = o[5:2];
        d.dest_explicit = !(o[5:2] == o[15:12] && o[1:0] == dfd_pkg::MOD_DIRECT);
      end
      dfd_pkg::CLS_WORKING_ZERO_ALIAS: d.group = dfd_pkg::GRP_WORD;
      dfd_pkg::CLS_FREG: begin
        d.group = dfd_pkg::GRP_WORD;
        d.file_form = 1'b1;
      end
      dfd_pkg::CLS_BIT: d.group = dfd_pkg::GRP_BIT;
      dfd_pkg::CLS_DSP: d.group = dfd_pkg::GRP_DSP;
      default: d.group = dfd_pkg::GRP_CTRL;
    endcase
    return d;
  endfunction : mk

  function automatic logic [47:0] pick(dfd_pkg::dfd_dec_s d);
    logic [31:0] k;
    case (d.opcode[7:5])
      dfd_pkg::CLS_WORKING_ZERO_ALIAS: k = {14'h0000, d.base_source_reg, d.result_dest_reg, d.dest_mode,
        d.second_source_reg, d.src_mode, d.byte_op, d.file_form};
      dfd_pkg::CLS_FREG: k = {17'h0_0000, d.file_addr, d.dest_to_file, d.file_form};
      dfd_pkg::CLS_BIT: k = {16'h0000, d.bit_indirect ? 4'h0 : d.bit_pos, d.bit_indirect, d.target_is_file,
        d.target_is_file ? d.file_addr[9:0] : {4'h0, d.second_source_reg, d.src_mode}};
      dfd_pkg::CLS_LIT_MOV: k = {7'h00, d.target_is_file, d.literal,
        d.target_is_file ? d.file_addr[7:0] : {4'h0, d.result_dest_reg}};
      dfd_pkg::CLS_LIT_ALU: k = {5'h00, d.base_source_reg, d.literal, d.dest_explicit, d.result_dest_reg, 2'h0};
      dfd_pkg::CLS_DSP: k = {18'h0_0000, d.acc_b, d.mac_pair, d.x_op, d.x_dest, d.y_op, d.y_dest, d.awb};
      default: k = d.is_two_word ? {16'h0000, d.ext_word} : 32'h0000_0000;
    endcase
    return {1'b0, d.group, d.opcode, d.is_two_word, d.is_nop, k};
  endfunction : pick

  function automatic logic [23:0] rs(logic [2:0] cls);
    logic [23:0] w;
    w = 24'($urandom);
    w[23:21] = cls;
    if (w[23:16] inside {dfd_pkg::OPC_TWO_A, dfd_pkg::OPC_TWO_B, dfd_pkg::OPC_TWO_C, dfd_pkg::OPC_DW_MOVE}) begin
      w[16] = ~w[16];
    end
    return w;
  endfunction : rs

  task automatic send(logic [23:0] w, logic [1:0] c, int nops);
    prog_u.words.push_back(w);
    prog_u.codes.push_back(c);
    exp_q.push_back({1'b0, pick(mk(w, 16'h0000, 1'b0))});
    repeat (nops) exp_q.push_back({1'b1, 48'h0000_0000_0000});
  endtask : send

  task automatic two(logic [7:0] op);
    logic [23:0] a;
    logic [23:0] b;
    a = {op, 16'($urandom)};
    b = {8'h00, 16'($urandom)};
    prog_u.words.push_back(a);
    prog_u.words.push_back(b);
    prog_u.codes.push_back(2'h0);
    exp_q.push_back({1'b0, pick(mk(a, b[15:0], 1'b1))});
  endtask : two

  task automatic drain(string n);
    int k;
    k = 0;
    while (exp_q.size() > 0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp_q.size(), 0);
    end
    repeat (4) @(negedge core_clk);
    $display("test %s done", n);
  endtask : drain

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////
  // oldest note against each issue or nop cycle
  always @(negedge core_clk) begin
    if (sys_rst === 1'b0 && (issue_valid === 1'b1 || issue_nop === 1'b1)) begin
      got = {issue_nop, issue_valid === 1'b1 ? pick(issue) : 48'h0000_0000_0000};
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
      checked++;
      if (got !== e || issue_valid === issue_nop) begin
        err_total++;
        $display("BAD t=%0t exp=%h got=%h", $time, e, got);
      end
    end
  end

  initial begin
    #(100 * 20000);
    err_total++;
    wrap_up();
  end

  initial begin
    sys_rst = 1'b1;
    err_total = 0;
    checked = 0;
    void'($urandom(29839));
    repeat (4) @(negedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < 64; i++) send(rs(i[2:0]), 2'h0, 0);
    drain("classes");
    prog_u.slow = 1'b1;
    for (int i = 0; i < 48; i++) send(rs(3'($urandom)), 2'h0, 0);
    drain("stalled");
    prog_u.slow = 1'b0;
    two(dfd_pkg::OPC_TWO_A);
    two(dfd_pkg::OPC_TWO_B);
    two(dfd_pkg::OPC_TWO_C);
    send({8'h00, 16'($urandom)}, 2'h0, 0);
    drain("two_word");
    send(rs(3'h3), 2'h1, 1);
    send(rs(3'h6), 2'h0, 0);
    send(rs(3'h5), 2'h2, 1);
    prog_u.words.push_back(rs(3'h4));
    send(rs(3'h2), 2'h0, 0);
    send(rs(3'h1), 2'h2, 2);
    prog_u.words.push_back({dfd_pkg::OPC_TWO_B, 16'($urandom)});
    prog_u.words.push_back({8'h00, 16'($urandom)});
    send({dfd_pkg::OPC_DW_MOVE, 16'($urandom)}, 2'h0, 1);
    send(rs(3'h3), 2'h0, 0);
    send(24'h40_3A4C, 2'h0, 0);
    send(rs(3'h1), 2'h0, 0);
    drain("flow");
    wrap_up();
  end
endmodule : testbench
